// ==== rtl/capcmp_pkg.sv ====
// Package: register map, field positions, reset values and modes
package capcmp_pkg;
   // ****************************************************************
   // Register byte addresses (AXI4-Lite, one word each)
   // ****************************************************************
   localparam logic [7:0] ADDR_MODE   = 8'h00; // timer_mode_control
   localparam logic [7:0] ADDR_OUTCTL = 8'h04; // output_control_reg
   localparam logic [7:0] ADDR_CCCTL  = 8'h08; // capture_compare_ctrl
   localparam logic [7:0] ADDR_CNT    = 8'h0c; // up_counter (read only)
   localparam logic [7:0] ADDR_CCA    = 8'h10; // capture_compare_a
   localparam logic [7:0] ADDR_CCB    = 8'h14; // capture_compare_b
   localparam logic [7:0] ADDR_EVT    = 8'h18; // event status, write 1 clr
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int MODE_OVF_BIT   = 0;  // overflow_flag
   localparam int MODE_SEL_LO    = 2;  // mode_select_low
   localparam int MODE_SEL_HI    = 3;  // mode_select_high
   localparam int OUT_EN_BIT     = 0;  // output enable
   localparam int OUT_TOGA_BIT   = 2;  // toggle on match A
   localparam int OUT_TOGB_BIT   = 4;  // toggle on match B
   localparam int OUT_OSE_BIT    = 5;  // oneshot_enable
   localparam int OUT_OST_BIT    = 6;  // oneshot_soft_trigger
   localparam int CC_A_CAP_BIT   = 0;  // register A is capture
   localparam int CC_A_SRC_BIT   = 1;  // A capture source: 1 = opposite A
   localparam int CC_B_CAP_BIT   = 2;  // register B is capture
   localparam int CC_EDGE_LO     = 4;  // input A valid edge select
   localparam int CC_EDGE_B_LO   = 6;  // input B valid edge select
   localparam int EVT_IRQ_A_BIT  = 0;  // match_irq_a seen
   localparam int EVT_IRQ_B_BIT  = 1;  // match_irq_b seen
   // ****************************************************************
   // Reset values and widths
   // ****************************************************************
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] CNT_MAX  = 16'hffff;
   // ****************************************************************
   // Modes, edge selects and bus responses
   // ****************************************************************
   localparam logic [1:0] MODE_STOP  = 2'b00;
   localparam logic [1:0] MODE_FREE  = 2'b01;
   localparam logic [1:0] MODE_EDGE  = 2'b10;
   localparam logic [1:0] MODE_MATCH = 2'b11;
   localparam logic [1:0] EDGE_FALL  = 2'b00;
   localparam logic [1:0] EDGE_RISE  = 2'b01;
   localparam logic [1:0] EDGE_BOTH  = 2'b11;
   localparam logic [1:0] RESP_OKAY  = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/edge_detect.sv ====
// Edge detector for one capture input: valid and opposite edge pulses
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Input pin and edge selection
   input  wire logic       pin_i,
   input  wire logic [1:0] edge_sel_i,
   // Edge pulses
   output logic            valid_o,
   output logic            opposite_o
);
   logic prev_reg;  // Last sample of the pin
   logic rise;      // Rising edge this cycle
   logic fall;      // Falling edge this cycle

   // ****************************************************************
   // Previous level
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= pin_i;
      end
   end

   assign rise = pin_i & ~prev_reg;
   assign fall = ~pin_i & prev_reg;

   // Decode valid and opposite edges from the selection
   always_comb begin
      valid_o    = 1'b0;
      opposite_o = 1'b0;
      case (edge_sel_i)
         capcmp_pkg::EDGE_FALL: begin
            valid_o    = fall;
            opposite_o = rise;
         end
         capcmp_pkg::EDGE_RISE: begin
            valid_o    = rise;
            opposite_o = fall;
         end
         capcmp_pkg::EDGE_BOTH: begin
            // Both edges valid: no opposite phase exists
            valid_o    = rise | fall;
         end
         default: begin
            valid_o    = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ==== rtl/oneshot_capture.sv ====
// Top: 16-bit capture/compare timer with one-shot and width capture
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Periodic period A+1, duty (A-B)/(A+1)
// - One-shot only in modes 01/10 with enable
// - Soft bit or A edge restarts, one pulse
// - Active after min+1, width is difference
// - One-shot matches raise irq, toggle pin
// - Mode 01: A edge->B, B edge->A
// - Single input: opposite->A, valid->B
// - Mode 10: valid edge captures B, clears
// - Device sets overflow; software clears it
// - Counter wraps after FFFF; overflow set except in mode 11
// - Opposite-edge capture raises no interrupt
module oneshot_capture (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // Pins
   input  wire logic        capture_input_a_i,
   input  wire logic        capture_input_b_i,
   output logic             timer_output_pin_o,
   output logic             match_irq_a_o,
   output logic             match_irq_b_o
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic        rst_meta_reg, rst_sync_reg; // Reset release chain
   logic [1:0]  mode_reg;        // mode_select_high/low
   logic        ovf_reg;         // overflow_flag
   logic [6:0]  outctl_reg;      // output_control_reg, trigger reads 0
   logic [7:0]  ccctl_reg;       // capture_compare_ctrl
   logic [15:0] up_counter_reg;  // Count value
   logic [15:0] cca_reg;         // capture_compare_a
   logic [15:0] ccb_reg;         // capture_compare_b
   logic [1:0]  evt_reg;         // Sticky match/capture events
   logic        os_busy_reg;     // One-shot pulse in progress
   logic        os_toggles_reg;  // Toggles seen in current one-shot
   logic        aw_got_reg, w_got_reg; // Write halves taken
   logic [7:0]  aw_addr_reg;     // Held write address
   logic [31:0] w_data_reg;      // Held write data
   logic [3:0]  w_strb_reg;      // Held byte enables
   logic        va, oa, vb;      // Edge pulses
   logic        running, os_mode, soft_trig, os_trig, restart;
   logic        match_a, match_b, cap_a, cap_b, cap_a_irq, toggle;
   logic        wr_fire;         // Both write halves present
   logic        wr_evt, wr_mode, wr_out;

   // ****************************************************************
   // Reset synchroniser
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // Edge detection on the capture inputs
   // ****************************************************************
   edge_detect u_edge_a (
      .clk_i      (sys_clk_i),
      .rst_b_i    (rst_sync_reg),
      .pin_i      (capture_input_a_i),
      .edge_sel_i (ccctl_reg[capcmp_pkg::CC_EDGE_LO +: 2]),
      .valid_o    (va),
      .opposite_o (oa)
   );
   edge_detect u_edge_b (
      .clk_i      (sys_clk_i),
      .rst_b_i    (rst_sync_reg),
      .pin_i      (capture_input_b_i),
      .edge_sel_i (ccctl_reg[capcmp_pkg::CC_EDGE_B_LO +: 2]),
      .valid_o    (vb),
      .opposite_o ()
   );

   // ****************************************************************
   // Control decode
   // ****************************************************************
   assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid_o;
   assign wr_mode = wr_fire & (aw_addr_reg == capcmp_pkg::ADDR_MODE)
                    & w_strb_reg[0];
   assign wr_out  = wr_fire & (aw_addr_reg == capcmp_pkg::ADDR_OUTCTL)
                    & w_strb_reg[0];
   assign wr_evt  = wr_fire & (aw_addr_reg == capcmp_pkg::ADDR_EVT)
                    & w_strb_reg[0];
   assign running = (mode_reg != capcmp_pkg::MODE_STOP);
   // One-shot allowed only in free-running or edge restart modes
   assign os_mode = outctl_reg[capcmp_pkg::OUT_OSE_BIT] &
                    ((mode_reg == capcmp_pkg::MODE_FREE) |
                     (mode_reg == capcmp_pkg::MODE_EDGE));
   assign soft_trig = wr_out & w_data_reg[capcmp_pkg::OUT_OST_BIT];
   assign os_trig = os_mode & (soft_trig | va);
   // Valid A edge restarts in mode 10 as well as on one-shot trigger
   assign restart = os_trig |
                    ((mode_reg == capcmp_pkg::MODE_EDGE) & va);
   assign match_a = running & ~ccctl_reg[capcmp_pkg::CC_A_CAP_BIT] &
                    (up_counter_reg == cca_reg);
   assign match_b = running & ~ccctl_reg[capcmp_pkg::CC_B_CAP_BIT] &
                    (up_counter_reg == ccb_reg);
   // Register B captures on valid A edge, register A on B or opposite A
   assign cap_b = running & ccctl_reg[capcmp_pkg::CC_B_CAP_BIT] & va;
   assign cap_a = running & ccctl_reg[capcmp_pkg::CC_A_CAP_BIT] &
                  (ccctl_reg[capcmp_pkg::CC_A_SRC_BIT] ? oa : vb);
   // Opposite-edge captures stay silent
   assign cap_a_irq = cap_a & ~ccctl_reg[capcmp_pkg::CC_A_SRC_BIT];
   // In one-shot, only the first two matches after a trigger toggle
   assign toggle = outctl_reg[capcmp_pkg::OUT_EN_BIT] &
      (os_mode ? (os_busy_reg & (match_a | match_b))
               : ((match_a & outctl_reg[capcmp_pkg::OUT_TOGA_BIT]) |
                  (match_b & outctl_reg[capcmp_pkg::OUT_TOGB_BIT])));

   // ****************************************************************
   // Counter: count, wrap, clear on restart, clear in stop
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         up_counter_reg <= capcmp_pkg::RST_WORD;
      end else if (!running) begin
         up_counter_reg <= capcmp_pkg::RST_WORD;
      end else if (restart) begin
         up_counter_reg <= capcmp_pkg::RST_WORD;
      end else if ((mode_reg == capcmp_pkg::MODE_MATCH) & match_a) begin
         // Period of compare A plus one clocks
         up_counter_reg <= capcmp_pkg::RST_WORD;
      end else begin
         up_counter_reg <= up_counter_reg + 16'h0001;
      end
   end

   // ****************************************************************
   // Overflow flag: set wins over software clear
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ovf_reg <= 1'b0;
      end else if (running & ~restart &
                   (mode_reg != capcmp_pkg::MODE_MATCH) &
                   (up_counter_reg == capcmp_pkg::CNT_MAX)) begin
         ovf_reg <= 1'b1;
      end else if (wr_mode & ~w_data_reg[capcmp_pkg::MODE_OVF_BIT]) begin
         ovf_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         mode_reg   <= capcmp_pkg::MODE_STOP;
         outctl_reg <= 7'h00;
         ccctl_reg  <= capcmp_pkg::RST_BYTE;
      end else if (wr_fire & w_strb_reg[0]) begin
         if (aw_addr_reg == capcmp_pkg::ADDR_MODE) begin
            mode_reg <= w_data_reg[capcmp_pkg::MODE_SEL_LO +: 2];
         end else if (aw_addr_reg == capcmp_pkg::ADDR_OUTCTL) begin
            // Trigger bit is a strobe, never stored
            outctl_reg <= {1'b0, w_data_reg[5:0]};
         end else if (aw_addr_reg == capcmp_pkg::ADDR_CCCTL) begin
            ccctl_reg <= w_data_reg[7:0];
         end
      end
   end

   // ****************************************************************
   // Capture/compare registers: software write or capture
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         cca_reg <= capcmp_pkg::RST_WORD;
         ccb_reg <= capcmp_pkg::RST_WORD;
      end else begin
         if (cap_a) begin
            cca_reg <= up_counter_reg;
         end else if (wr_fire & (aw_addr_reg == capcmp_pkg::ADDR_CCA)) begin
            if (w_strb_reg[0]) cca_reg[7:0]  <= w_data_reg[7:0];
            if (w_strb_reg[1]) cca_reg[15:8] <= w_data_reg[15:8];
         end
         if (cap_b) begin
            ccb_reg <= up_counter_reg;
         end else if (wr_fire & (aw_addr_reg == capcmp_pkg::ADDR_CCB)) begin
            if (w_strb_reg[0]) ccb_reg[7:0]  <= w_data_reg[7:0];
            if (w_strb_reg[1]) ccb_reg[15:8] <= w_data_reg[15:8];
         end
      end
   end

   // ****************************************************************
   // One-shot tracking and output pin
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         os_busy_reg        <= 1'b0;
         os_toggles_reg     <= 1'b0;
         timer_output_pin_o <= 1'b0;
      end else begin
         if (os_trig) begin
            // Retrigger mid-pulse is the caller's fault; restart cleanly
            os_busy_reg    <= 1'b1;
            os_toggles_reg <= 1'b0;
         end else if (os_busy_reg & toggle) begin
            os_toggles_reg <= 1'b1;
            if (os_toggles_reg) os_busy_reg <= 1'b0;
         end else if (!os_mode) begin
            os_busy_reg <= 1'b0;
         end
         if (!running) begin
            timer_output_pin_o <= 1'b0;
         end else if (toggle) begin
            timer_output_pin_o <= ~timer_output_pin_o;
         end
      end
   end

   // ****************************************************************
   // Interrupt pulses and sticky events (set wins over clear)
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         match_irq_a_o <= 1'b0;
         match_irq_b_o <= 1'b0;
         evt_reg       <= 2'b00;
      end else begin
         match_irq_a_o <= match_a | cap_a_irq;
         match_irq_b_o <= match_b | cap_b;
         evt_reg <= (evt_reg & ~({2{wr_evt}} & w_data_reg[1:0])) |
                    {match_b | cap_b, match_a | cap_a_irq};
      end
   end

   // ****************************************************************
   // AXI4-Lite write channel: take AW and W in any order
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         aw_got_reg      <= 1'b0;
         w_got_reg       <= 1'b0;
         aw_addr_reg     <= 8'h00;
         w_data_reg      <= 32'h0000_0000;
         w_strb_reg      <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= capcmp_pkg::RESP_OKAY;
      end else begin
         s_axi_awready_o <= ~aw_got_reg & ~s_axi_awready_o;
         s_axi_wready_o  <= ~w_got_reg & ~s_axi_wready_o;
         if (s_axi_awvalid_i & s_axi_awready_o) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i & s_axi_wready_o) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_fire) begin
            aw_got_reg     <= 1'b0;
            w_got_reg      <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (aw_addr_reg > capcmp_pkg::ADDR_EVT)
                              ? capcmp_pkg::RESP_SLVERR
                              : capcmp_pkg::RESP_OKAY;
         end else if (s_axi_bvalid_o & s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel: one read at a time
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= capcmp_pkg::RESP_OKAY;
      end else begin
         s_axi_arready_o <= ~s_axi_rvalid_o & ~s_axi_arready_o &
                            ~s_axi_arvalid_i ? 1'b1 :
                            (~s_axi_rvalid_o & ~s_axi_arready_o);
         if (s_axi_arvalid_i & s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rresp_o   <= capcmp_pkg::RESP_OKAY;
            if (s_axi_araddr_i == capcmp_pkg::ADDR_MODE) begin
               s_axi_rdata_o <= {28'h0, mode_reg, 1'b0, ovf_reg};
            end else if (s_axi_araddr_i == capcmp_pkg::ADDR_OUTCTL) begin
               s_axi_rdata_o <= {25'h0, outctl_reg};
            end else if (s_axi_araddr_i == capcmp_pkg::ADDR_CCCTL) begin
               s_axi_rdata_o <= {24'h0, ccctl_reg};
            end else if (s_axi_araddr_i == capcmp_pkg::ADDR_CNT) begin
               s_axi_rdata_o <= {16'h0, up_counter_reg};
            end else if (s_axi_araddr_i == capcmp_pkg::ADDR_CCA) begin
               s_axi_rdata_o <= {16'h0, cca_reg};
            end else if (s_axi_araddr_i == capcmp_pkg::ADDR_CCB) begin
               s_axi_rdata_o <= {16'h0, ccb_reg};
            end else if (s_axi_araddr_i == capcmp_pkg::ADDR_EVT) begin
               s_axi_rdata_o <= {30'h0, evt_reg};
            end else begin
               s_axi_rdata_o <= 32'h0000_0000;
               s_axi_rresp_o <= capcmp_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rvalid_o & s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/pulse_source.sv ====
// Partner model: external pulse sources driving both capture inputs
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
   // Clock and requested levels
   input  wire logic clk_i,
   input  wire logic lvl_a_i,
   input  wire logic lvl_b_i,
   // Capture pins, glitch free between requested changes
   output logic      cap_a_o = 1'b0,
   output logic      cap_b_o = 1'b0
);
   // Levels move only on a clock edge, so no stray trigger appears
   always @(posedge clk_i) begin
      cap_a_o <= lvl_a_i;
      cap_b_o <= lvl_b_i;
   end
endmodule
`default_nettype wire

// ==== bench/oneshot_capture_sva.sv ====
// Checker: port-level assertions for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
module oneshot_capture_checker (
   // Clock, reset, bus handshakes and pins
   input wire logic sys_clk_i, rst_b_i, s_axi_wvalid_i, s_axi_wready_o,
   input wire logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i,
   input wire logic s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
   input wire logic timer_output_pin_o, match_irq_a_o, match_irq_b_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic [31:0] s_axi_rdata_o
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Requests accepted on the write data and read address channels
   sequence s_w_take; s_axi_wvalid_i && s_axi_wready_o; endsequence
   sequence s_ar_take; s_axi_arvalid_i && s_axi_arready_o; endsequence
   AST_IRQ_A_PULSE:
      assert property (match_irq_a_o |=> !match_irq_a_o) else $error("irq a long");
   AST_IRQ_B_PULSE:
      assert property (match_irq_b_o |=> !match_irq_b_o) else $error("irq b long");
   AST_PIN_RISE_CAUSE:
      assert property ($rose(timer_output_pin_o) |-> match_irq_a_o || match_irq_b_o)
         else $error("pin rose without a match");
   AST_QUIET_START:
      assert property ($rose(rst_b_i) |-> !timer_output_pin_o && !match_irq_a_o)
         else $error("outputs busy after reset");
   AST_B_HOLD:
      assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
         && $stable(s_axi_bresp_o)) else $error("write response dropped");
   AST_R_HOLD:
      assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
         && $stable(s_axi_rdata_o)) else $error("read data dropped");
   AST_R_NEXT:
      assert property (s_ar_take |=> s_axi_rvalid_o) else $error("read late");
   AST_B_SOON:
      assert property (s_w_take |-> ##[1:3] s_axi_bvalid_o) else $error("no bresp");
endmodule
bind oneshot_capture oneshot_capture_checker oneshot_capture_checker_i (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .timer_output_pin_o(timer_output_pin_o),
   .match_irq_a_o(match_irq_a_o), .match_irq_b_o(match_irq_b_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_rdata_o(s_axi_rdata_o));
`default_nettype wire

// ==== bench/testbench.sv ====
// Testbench: self-checking scenarios for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   // ****************
   // Signals and register aliases
   // ****************
   localparam logic [7:0] MD = capcmp_pkg::ADDR_MODE, OC = capcmp_pkg::ADDR_OUTCTL;
   localparam logic [7:0] CC = capcmp_pkg::ADDR_CCCTL, RA = capcmp_pkg::ADDR_CCA;
   localparam logic [7:0] RB = capcmp_pkg::ADDR_CCB, CN = capcmp_pkg::ADDR_CNT;
   logic        clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
   logic        arv = 1'b0, rr = 1'b0, la = 1'b0, lb = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd, v1;
   logic [1:0]  rs, bs;
   wire logic   awr, wr, bv, arr, rv, pin, ia, ib, ca, cb;
   wire logic [1:0]  rres, bres;
   wire logic [31:0] rdat;
   int errors = 0, check_count = 0, na = 0, nb = 0, w, h, n0, n1;
   initial begin
      forever #5 clk = ~clk;
   end
   // Pulses tallied on the quiet edge, away from the design's updates
   always @(negedge clk) begin
      if (ia === 1'b1) na++;
      if (ib === 1'b1) nb++;
   end
   oneshot_capture oneshot_capture_i (.sys_clk_i(clk), .rst_b_i(rst_b),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr), .s_axi_bresp_o(bres), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rres),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .capture_input_a_i(ca),
      .capture_input_b_i(cb), .timer_output_pin_o(pin),
      .match_irq_a_o(ia), .match_irq_b_o(ib));
   pulse_source pulse_source_i (.clk_i(clk), .lvl_a_i(la), .lvl_b_i(lb),
      .cap_a_o(ca), .cap_b_o(cb));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic bail;
      errors++;
      tally_and_finish;
   endtask
   // Bus write: each channel released at the edge that takes it
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(negedge clk); ta = awv & awr; tw = wv & wr; bs = bres;
         if (bv & br) begin @(posedge clk); br <= 1'b0; @(posedge clk); return; end
         @(posedge clk); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0;
      end
      bail;
   endtask
   task automatic axr(input logic [7:0] a);
      logic ta;
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(negedge clk); ta = arv & arr; rd = rdat; rs = rres;
         if (rv & rr) begin @(posedge clk); rr <= 1'b0; @(posedge clk); return; end
         @(posedge clk); if (ta) arv <= 1'b0;
      end
      bail;
   endtask
   // Length of the next run of level v; returns on a rising edge so the
   // following span counts its first cycle at once
   task automatic span(input logic v);
      w = 0;
      while (pin !== v) begin @(negedge clk); if (++w > 500) bail; end
      w = 0;
      while (pin === v) begin w++; @(negedge clk); if (w > 500) bail; end
      @(posedge clk);
   endtask
   task automatic cfg(input logic [31:0] m, o, c);
      axw(MD, 32'h0); axw(CC, c); axw(MD, m); axw(OC, o);
   endtask
   task automatic t_stop;
      axw(OC, 32'h75); `CHK(bs, capcmp_pkg::RESP_OKAY)
      repeat (20) @(negedge clk);
      `CHK(pin, 1'b0)
      @(posedge clk); axr(CN); `CHK(rd, 32'h0)
      axr(8'h1c); `CHK(rs, capcmp_pkg::RESP_SLVERR)
      axw(8'h1c, 32'h0); `CHK(bs, capcmp_pkg::RESP_SLVERR)
      $display("test stop done");
   endtask
   task automatic t_oneshot;
      axw(RA, 32'ha); axw(RB, 32'h4);
      cfg(32'h4, 32'h75, 32'h10); n0 = na + nb;
      span(1'b0); span(1'b1); `CHK(w, 6)
      `CHK(na + nb - n0, 2)
      la <= 1'b1; span(1'b0); span(1'b1); `CHK(w, 6)
      $display("test oneshot done");
   endtask
   task automatic t_periodic;
      la <= 1'b0; axw(RA, 32'h9); axw(RB, 32'h4); cfg(32'hc, 32'h15, 32'h0);
      span(1'b0); span(1'b1); h = w; span(1'b0);
      `CHK(h, 5)
      `CHK(w, 5)
      $display("test periodic done");
   endtask
   task automatic t_cap_two;
      cfg(32'h4, 32'h0, 32'hf5); n0 = na; n1 = nb;
      la <= 1'b1; repeat (7) @(posedge clk); lb <= 1'b1; repeat (4) @(posedge clk);
      axr(RA); v1 = rd; axr(RB); `CHK(16'(v1 - rd), 16'h0007)
      `CHK(na - n0, 1)
      `CHK(nb - n1, 1)
      $display("test two inputs done");
   endtask
   task automatic t_single(input logic [31:0] m);
      la <= 1'b0; cfg(m, 32'h0, 32'h17); repeat (100) @(posedge clk); n0 = na;
      la <= 1'b1; repeat (9) @(posedge clk); la <= 1'b0; repeat (6) @(posedge clk);
      la <= 1'b1; repeat (4) @(posedge clk);
      axr(RB); v1 = rd; axr(RA); `CHK(16'(v1 - rd), 16'h0006)
      `CHK(v1[15:0] < 16'h0020, m == 32'h8)
      `CHK(na - n0, 0)
      $display("test single input done");
   endtask
   task automatic t_ovf;
      cfg(32'h4, 32'h0, 32'h0); repeat (65556) @(posedge clk);
      axr(MD); `CHK(rd[0], 1'b1)
      axw(MD, 32'h4); axr(MD); `CHK(rd[0], 1'b0)
      $display("test overflow done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_stop;
      t_oneshot;
      t_periodic;
      t_cap_two;
      t_single(32'h4);
      t_single(32'h8);
      t_ovf;
      tally_and_finish;
   end
endmodule
`default_nettype wire
